// ==== hdl/rre_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module rre_exec #(
    parameter int DATA_W = rre_pkg::DATA_W,
    parameter int PC_W = rre_pkg::PC_W,
    parameter int SP_W = rre_pkg::SP_W,
    parameter int FADDR_W = rre_pkg::FADDR_W
) (
    input wire logic mclk,
    input wire logic srst,
    // one-cycle instruction strobe with its decoded fields
    input wire logic instr_valid,
    input wire rre_pkg::rre_op_t instr_op,
    input wire logic [DATA_W-1:0] instr_literal,
    input wire logic [FADDR_W-1:0] instr_faddr,
    input wire logic instr_dest,
    // surrounding core state
    input wire logic [PC_W-1:0] top_of_return_stack,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic carry_in,
    input wire logic [DATA_W-1:0] interrupt_control_register,
    output logic busy,
    output logic [PC_W-1:0] pc,
    output logic [SP_W-1:0] stack_ptr,
    output logic [DATA_W-1:0] w_reg_out,
    output logic carry_we,
    output logic carry_out,
    output logic file_we,
    output logic [FADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic interrupt_control_register_we,
    output logic [DATA_W-1:0] interrupt_control_register_wdata,
    output logic pc_load
);
    // ==================================================
    // rotate datapath
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;
    logic is_rot;
    logic is_ret;

    rre_rotate #(.DATA_W(DATA_W)) u_rotate (
        .src(file_rdata),
        .carry_in(carry_in),
        .dir_right(instr_op == rre_pkg::RRE_OP_ROT_RIGHT),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // ==================================================
    // execution state
    rre_pkg::rre_state_t state_reg, state_next;
    logic busy_reg, busy_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic pcl_reg, pcl_next;
    logic [SP_W-1:0] sp_reg, sp_next;
    logic [DATA_W-1:0] w_reg, w_next;
    logic carry_we_reg, carry_we_next;
    logic carry_reg, carry_next;
    logic fwe_reg, fwe_next;
    logic [FADDR_W-1:0] faddr_reg, faddr_next;
    logic [DATA_W-1:0] fdata_reg, fdata_next;
    logic iwe_reg, iwe_next;
    logic [DATA_W-1:0] idata_reg, idata_next;
    logic take_ret;
    logic take_rot;

    // ==================================================
    // instruction decode
    // a strobe seen in the second cycle of a return is dropped, not queued
    always_comb begin
        is_rot = (instr_op == rre_pkg::RRE_OP_ROT_LEFT) ||
                 (instr_op == rre_pkg::RRE_OP_ROT_RIGHT);
        is_ret = (instr_op == rre_pkg::RRE_OP_RET_INT) ||
                 (instr_op == rre_pkg::RRE_OP_RET_SUB) ||
                 (instr_op == rre_pkg::RRE_OP_RET_LIT);
        take_ret = instr_valid && is_ret &&
                   (state_reg == rre_pkg::RRE_ST_IDLE);
        take_rot = instr_valid && is_rot &&
                   (state_reg == rre_pkg::RRE_ST_IDLE);
    end

    // ==================================================
    // sequencing: program counter, stack pointer, second cycle
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        pcl_next = 1'b0;
        sp_next = sp_reg;
        unique case (state_reg)
            rre_pkg::RRE_ST_IDLE: begin
                if (take_ret) begin
                    pc_next = top_of_return_stack;
                    pcl_next = 1'b1;
                    // an empty stack wraps: the pointer has no guard
                    sp_next = sp_reg - SP_W'(1);
                    // second cycle flushes the word already fetched
                    state_next = rre_pkg::RRE_ST_FLUSH;
                end
            end
            rre_pkg::RRE_ST_FLUSH: begin
                state_next = rre_pkg::RRE_ST_IDLE;
            end
        endcase
        busy_next = (state_next == rre_pkg::RRE_ST_FLUSH);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= rre_pkg::RRE_ST_IDLE;
            busy_reg <= 1'b0;
            pc_reg <= PC_W'(rre_pkg::PC_RESET);
            pcl_reg <= 1'b0;
            sp_reg <= SP_W'(rre_pkg::SP_RESET);
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            pc_reg <= pc_next;
            pcl_reg <= pcl_next;
            sp_reg <= sp_next;
        end
    end

    // ==================================================
    // working register
    always_comb begin
        w_next = w_reg;
        if (take_ret && (instr_op == rre_pkg::RRE_OP_RET_LIT)) begin
            w_next = instr_literal;
        end else if (take_rot && !instr_dest) begin
            w_next = rot_result;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            w_reg <= DATA_W'(rre_pkg::W_RESET);
        end else begin
            w_reg <= w_next;
        end
    end

    // ==================================================
    // carry flag
    always_comb begin
        carry_we_next = 1'b0;
        carry_next = carry_reg;
        // returns touch no arithmetic flag: carry_we stays low
        if (take_rot) begin
            carry_we_next = 1'b1;
            carry_next = rot_carry;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            carry_we_reg <= 1'b0;
            carry_reg <= 1'b0;
        end else begin
            carry_we_reg <= carry_we_next;
            carry_reg <= carry_next;
        end
    end

    // ==================================================
    // file register write-back
    always_comb begin
        fwe_next = 1'b0;
        faddr_next = faddr_reg;
        fdata_next = fdata_reg;
        if (take_rot && instr_dest) begin
            fwe_next = 1'b1;
            faddr_next = instr_faddr;
            fdata_next = rot_result;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            fwe_reg <= 1'b0;
            faddr_reg <= '0;
            fdata_reg <= '0;
        end else begin
            fwe_reg <= fwe_next;
            faddr_reg <= faddr_next;
            fdata_reg <= fdata_next;
        end
    end

    // ==================================================
    // interrupt control write
    // read-modify-write of the supplied value: only the enable bit moves
    always_comb begin
        iwe_next = 1'b0;
        idata_next = idata_reg;
        if (take_ret && (instr_op == rre_pkg::RRE_OP_RET_INT)) begin
            iwe_next = 1'b1;
            idata_next = interrupt_control_register;
            idata_next[rre_pkg::GIE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            iwe_reg <= 1'b0;
            idata_reg <= '0;
        end else begin
            iwe_reg <= iwe_next;
            idata_reg <= idata_next;
        end
    end

    // ==================================================
    // outputs, all registered
    always_comb begin
        busy = busy_reg;
        pc = pc_reg;
        stack_ptr = sp_reg;
        w_reg_out = w_reg;
        carry_we = carry_we_reg;
        carry_out = carry_reg;
        file_we = fwe_reg;
        file_waddr = faddr_reg;
        file_wdata = fdata_reg;
        interrupt_control_register_we = iwe_reg;
        interrupt_control_register_wdata = idata_reg;
        pc_load = pcl_reg;
    end
endmodule : rre_exec
`default_nettype wire

// ==== hdl/rre_pkg.sv ====
// Overview of operation
// - interrupt return pops stack, loads pc, two cycles
// - interrupt return sets enable bit 7, no flags
// - subroutine return pops stack into pc, two cycles
// - literal return loads w and pc, two cycles
// - rotate left through carry, single cycle
// - destination bit picks w or file register
// - rotate right through carry, same destination choice
`default_nettype none
package rre_pkg;
    // ==================================================
    // widths and encodings
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int SP_W = 4;
    localparam int FADDR_W = 7;
    localparam int GIE_BIT = 7;
    localparam int RETURN_CYCLES = 2;
    localparam logic [SP_W-1:0] SP_RESET = 4'hf;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] W_RESET = 8'h00;

    typedef enum logic [2:0] {
        RRE_OP_NONE,
        RRE_OP_RET_INT,
        RRE_OP_RET_SUB,
        RRE_OP_RET_LIT,
        RRE_OP_ROT_LEFT,
        RRE_OP_ROT_RIGHT
    } rre_op_t;

    typedef enum logic {
        RRE_ST_IDLE,
        RRE_ST_FLUSH
    } rre_state_t;
endpackage : rre_pkg
`default_nettype wire

// ==== hdl/rre_rotate.sv ====
`timescale 1ns/1ps
`default_nettype none
module rre_rotate #(
    parameter int DATA_W = 8
) (
    input wire logic [DATA_W-1:0] src,
    input wire logic carry_in,
    input wire logic dir_right,
    output logic [DATA_W-1:0] result,
    output logic carry_out
);
    always_comb begin
        if (dir_right) begin
            result = {carry_in, src[DATA_W-1:1]};
            carry_out = src[0];
        end else begin
            result = {src[DATA_W-2:0], carry_in};
            carry_out = src[DATA_W-1];
        end
    end
endmodule : rre_rotate
`default_nettype wire

// ==== sim/rre_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rre_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire logic instr_valid,
    input wire rre_pkg::rre_op_t instr_op,
    input wire logic [7:0] instr_literal,
    input wire logic instr_dest,
    input wire logic carry_in,
    input wire logic [14:0] top_of_return_stack,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] interrupt_control_register,
    input wire logic busy,
    input wire logic [14:0] pc,
    input wire logic [3:0] stack_ptr,
    input wire logic [7:0] w_reg_out,
    input wire logic carry_we,
    input wire logic carry_out,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic interrupt_control_register_we,
    input wire logic [7:0] interrupt_control_register_wdata,
    input wire logic pc_load
);
    logic tk;
    assign tk = instr_valid && !busy;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // ==========
    // opcode order: 1..3 returns, 4 left, 5 right
    sequence s_ret; tk && instr_op inside {[3'h1:3'h3]}; endsequence
    sequence s_rl; tk && instr_op == 3'h4; endsequence
    sequence s_rr; tk && instr_op == 3'h5; endsequence
    sequence s_two; busy ##1 !busy; endsequence
    a_ret_pc: assert property (s_ret |=> pc_load &&
        pc == $past(top_of_return_stack)) else $error("pc");
    a_ret_two: assert property (s_ret |=> s_two)
        else $error("return length");
    a_int_gie: assert property (tk && instr_op == 3'h1 |=>
        interrupt_control_register_we &&
        interrupt_control_register_wdata == ($past(interrupt_control_register) | 8'h80))
        else $error("enable");
    a_lit_w: assert property (tk && instr_op == 3'h3 |=>
        w_reg_out == $past(instr_literal)) else $error("literal");
    a_rl_carry: assert property (s_rl |=> carry_we &&
        carry_out == |($past(file_rdata) & 8'h80)) else $error("left");
    a_rr_carry: assert property (s_rr |=> carry_we &&
        carry_out == |($past(file_rdata) & 8'h01)) else $error("right");
    a_rot_dest: assert property (s_rl or s_rr |=>
        file_we == $past(instr_dest) && !pc_load) else $error("dest");
    a_sp_pop: assert property (s_ret |=> stack_ptr ==
        $past(stack_ptr) - 4'h1) else $error("pop");
    a_ret_no_flag: assert property (s_ret |=>
        !carry_we && !file_we) else $error("return flag");
    a_rl_data: assert property (s_rl |=>
        (file_we ? file_wdata : w_reg_out) ==
        {$past(file_rdata[6:0]), $past(carry_in)}) else $error("left data");
    a_rr_data: assert property (s_rr |=>
        (file_we ? file_wdata : w_reg_out) ==
        {$past(carry_in), $past(file_rdata[7:1])}) else $error("right data");
    a_busy_drop: assert property (instr_valid && busy |=>
        !pc_load && !carry_we && !file_we && !interrupt_control_register_we)
        else $error("busy take");
endmodule : rre_monitor
bind rre_exec rre_monitor u_mon (.*);
`default_nettype wire

// ==== sim/return_and_rotate_execution_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_execution_tb;
    logic mclk = 1'b0, srst = 1'b1, instr_valid = 1'b0, instr_dest = 1'b0;
    logic carry_in = 1'b0, busy, carry_we, carry_out, file_we, interrupt_control_register_we;
    logic pc_load;
    rre_pkg::rre_op_t instr_op = rre_pkg::RRE_OP_NONE;
    logic [7:0] instr_literal = 8'h00, file_rdata = 8'h00, w_reg_out;
    logic [7:0] interrupt_control_register = 8'h00;
    logic [7:0] file_wdata, interrupt_control_register_wdata;
    logic [6:0] instr_faddr = 7'h00, file_waddr;
    logic [14:0] top_of_return_stack = 15'h0000, pc;
    logic [3:0] stack_ptr;
    int n_errors = 0, n_tests = 0;
    rre_exec dut (.*);
    initial forever #12.5 mclk = ~mclk;
    task chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // ==========
    // one instruction, sampled after its answer edge
    task issue(input rre_pkg::rre_op_t op, input logic [7:0] d,
               input logic c, dst, hold);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_literal <= d;
        file_rdata <= d;
        interrupt_control_register <= ~d;
        top_of_return_stack <= {d[6:0], ~d};
        instr_faddr <= ~d[6:0];
        carry_in <= c;
        instr_dest <= dst;
        @(posedge mclk);
        instr_valid <= hold;
        #1;
    endtask : issue
    task t_ret(input rre_pkg::rre_op_t op, input logic [7:0] d);
        logic [3:0] sp;
        logic [7:0] w0;
        sp = stack_ptr - 4'h1;
        w0 = w_reg_out;
        // strobe held into the busy cycle must not pop twice
        issue(op, d, 1'b1, 1'b1, 1'b1);
        chk(pc, {d[6:0], ~d});
        chk({pc_load, busy, carry_we}, 3'h6);
        chk(stack_ptr, sp);
        chk(interrupt_control_register_we, op == rre_pkg::RRE_OP_RET_INT);
        if (op == rre_pkg::RRE_OP_RET_INT)
            chk(interrupt_control_register_wdata, 8'(~d | 8'h80));
        chk(w_reg_out, (op == rre_pkg::RRE_OP_RET_LIT) ? d : w0);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk({pc_load, busy, stack_ptr}, {2'b00, sp});
        $display("return done");
    endtask : t_ret
    task t_rot(input logic rt, dst, c, input logic [7:0] d);
        logic [7:0] r;
        logic [7:0] w0;
        w0 = w_reg_out;
        r = rt ? {c, d[7:1]} : {d[6:0], c};
        issue(rt ? rre_pkg::RRE_OP_ROT_RIGHT : rre_pkg::RRE_OP_ROT_LEFT,
              d, c, dst, 1'b0);
        chk({carry_we, file_we, pc_load}, {1'b1, dst, 1'b0});
        chk(carry_out, rt ? d[0] : d[7]);
        chk(dst ? file_wdata : w_reg_out, r);
        if (dst) chk({file_waddr, w_reg_out}, {~d[6:0], w0});
        @(posedge mclk);
        #1;
        chk(carry_we, 1'b0);
        $display("rotate done");
    endtask : t_rot
    task t_reset;
        @(posedge mclk);
        srst <= 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk({pc, stack_ptr, w_reg_out}, 27'h0000f00);
        chk({busy, pc_load, carry_we, file_we, interrupt_control_register_we}, 5'h00);
        $display("reset done");
    endtask : t_reset
    task t_none;
        logic [14:0] pc0;
        logic [3:0] sp0;
        pc0 = pc;
        sp0 = stack_ptr;
        issue(rre_pkg::RRE_OP_NONE, 8'h5a, 1'b1, 1'b1, 1'b0);
        chk({pc, stack_ptr}, {pc0, sp0});
        chk({pc_load, carry_we, file_we, interrupt_control_register_we}, 4'h0);
        $display("idle op done");
    endtask : t_none
    initial begin
        t_reset;
        t_none;
        t_ret(rre_pkg::RRE_OP_RET_INT, 8'hb5);
        t_ret(rre_pkg::RRE_OP_RET_SUB, 8'h3c);
        t_ret(rre_pkg::RRE_OP_RET_LIT, 8'hc7);
        for (int i = 0; i < 8; i++) t_rot(i[0], i[1], i[2], 8'he6 ^ 8'(i));
        // reset in mid-run, then a return must work from a fresh pointer
        t_reset;
        t_ret(rre_pkg::RRE_OP_RET_LIT, 8'h69);
        give_verdict;
    end
    initial begin
        repeat (400) @(posedge mclk);
        n_errors++;
        give_verdict;
    end
endmodule : return_and_rotate_execution_tb
`default_nettype wire
